// ===== hdl/lp_retention_pkg.sv
/*
 * constants, field layout and carrier types for the low-power retention
 * control block. assumes a single 200 MHz clock domain and an APB master.
 */
// Overview of operation
// - the retention-regulator select bit resets to 1 and powers the dedicated regulator in backup; at 0 the main supply keeps the banks instead.
// - setting the supply-detection bypass bit skips external core-supply detection; at 0 detection stays on.
// - bits 5 to 4 choose the regulator output voltage range and hold 2 after reset.
// - bank 3 select keeps bank 3 contents in backup mode when 1, not when 0, reset 0.
// - bank 2 select keeps bank 2 contents in backup mode when 1, not when 0, reset 0.
// - bank 1 select keeps bank 1 contents in backup mode when 1, not when 0, reset 0.
// - bank 0 select keeps bank 0 contents in backup mode when 1, not when 0, reset 0.
`default_nettype none
package lp_retention_pkg;
    // ==========================================================
    // register map
    localparam logic [11:0] OFF_LOW_POWER_VOLTAGE_CONTROL = 12'h000;
    localparam int BANK_COUNT = 4;
    localparam int POS_BANK_KEEP = 0;
    localparam int POS_RANGE_LO = 4;
    localparam int POS_RANGE_HI = 5;
    localparam int POS_DET_BYPASS = 6;
    localparam int POS_RESV_LO = 7;
    localparam int POS_RET_REG = 8;
    localparam int POS_RESV_HI = 9;
    localparam logic [3:0] RST_BANK_KEEP = 4'h0;
    localparam logic [1:0] RST_RANGE = 2'h2;
    localparam logic RST_DET_BYPASS = 1'b0;
    localparam logic RST_RET_REG = 1'b1;
    localparam logic RST_RESV = 1'b0;
    localparam logic [31:0] ERR_READ_DATA = 32'h0000_0000;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic resvHi;
        logic retRegEnable;
        logic resvLo;
        logic detBypass;
        logic [1:0] voltRange;
        logic [3:0] bankKeep;
    } lp_ctrl_t;

    typedef struct packed {
        logic dedicatedRegOn;
        logic [3:0] bankRetainMain;
        logic [3:0] bankRetainDedicated;
        logic [3:0] bankPowerOff;
    } retain_drive_t;
endpackage : lp_retention_pkg
`default_nettype wire

// ===== hdl/bank_retain_map.sv
/*
 * per-bank retention steering from the stored selections.
 * assumes the backup-mode level arrives synchronous to clk_sys.
 */
`timescale 1ns/1ps
`default_nettype none
module bank_retain_map (
    input wire logic inBackup,
    input wire lp_retention_pkg::lp_ctrl_t ctrl,
    output wire lp_retention_pkg::retain_drive_t drive
);
    import lp_retention_pkg::*;

    genvar b;
    // ==========================================================
    // bank steering
    generate
        for (b = 0; b < BANK_COUNT; b++) begin : g_bank
            // a bank not kept loses power only in backup; outside it all run
            assign drive.bankRetainDedicated[b] = inBackup && ctrl.bankKeep[b]
                && ctrl.retRegEnable;
            assign drive.bankRetainMain[b] = inBackup && ctrl.bankKeep[b]
                && !ctrl.retRegEnable;
            assign drive.bankPowerOff[b] = inBackup && !ctrl.bankKeep[b];
        end
    endgenerate
    assign drive.dedicatedRegOn = inBackup && ctrl.retRegEnable;
endmodule : bank_retain_map
`default_nettype wire

// ===== hdl/low_power_retention_control.sv
/*
 * low-power voltage control register (low ten bits) on APB, plus the
 * steering of regulator, detection bypass and bank retention outputs.
 * assumes the power sequencer gives a synchronous backup-mode level.
 */
`timescale 1ns/1ps
`default_nettype none
module low_power_retention_control (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic clkEn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic inBackup,
    output var lp_retention_pkg::retain_drive_t retainDrive,
    output logic [1:0] regulatorRange,
    output logic supplyDetectBypass
);
    import lp_retention_pkg::*;

    lp_ctrl_t ctrl_ff;
    lp_ctrl_t nxt_ctrl;
    retain_drive_t driveComb;
    logic setupPhase;
    logic hit;
    logic wrStrobe;
    typedef enum logic [1:0] {
        S_IDLE = 2'b01,
        S_ACK = 2'b10
    } apb_state_t;
    apb_state_t state_ff;

    assign hit = (paddr == OFF_LOW_POWER_VOLTAGE_CONTROL);
    assign setupPhase = psel && !penable;
    assign wrStrobe = psel && penable && pready && pwrite && hit;

    // ==========================================================
    // apb handshake: no wait state, answer at the first access edge
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state_ff <= S_IDLE;
        end else if (clkEn) begin
            case (state_ff)
                S_IDLE: begin
                    if (setupPhase) begin
                        state_ff <= S_ACK;
                    end
                end
                S_ACK: begin
                    state_ff <= S_IDLE;
                end
                default: begin
                    state_ff <= S_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            pready <= 1'b0;
        end else if (clkEn) begin
            pready <= (state_ff == S_IDLE) && setupPhase;
        end
    end

    // ==========================================================
    // register write, byte lanes 0 and 1 carry the fields
    always_comb begin
        nxt_ctrl = ctrl_ff;
        if (pstrb[0]) begin
            nxt_ctrl.bankKeep = pwdata[POS_BANK_KEEP +: BANK_COUNT];
            nxt_ctrl.voltRange = pwdata[POS_RANGE_HI:POS_RANGE_LO];
            nxt_ctrl.detBypass = pwdata[POS_DET_BYPASS];
            nxt_ctrl.resvLo = pwdata[POS_RESV_LO];
        end
        if (pstrb[1]) begin
            nxt_ctrl.retRegEnable = pwdata[POS_RET_REG];
            nxt_ctrl.resvHi = pwdata[POS_RESV_HI];
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            ctrl_ff.bankKeep <= RST_BANK_KEEP;
            ctrl_ff.voltRange <= RST_RANGE;
            ctrl_ff.detBypass <= RST_DET_BYPASS;
            ctrl_ff.resvLo <= RST_RESV;
            ctrl_ff.retRegEnable <= RST_RET_REG;
            ctrl_ff.resvHi <= RST_RESV;
        end else if (clkEn && wrStrobe) begin
            ctrl_ff <= nxt_ctrl;
        end
    end

    // ==========================================================
    // read data and error, registered with the ready
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            prdata <= ERR_READ_DATA;
            pslverr <= 1'b0;
        end else if (clkEn) begin
            if ((state_ff == S_IDLE) && setupPhase) begin
                pslverr <= !hit;
                // readback of the last written value, upper bits zero
                prdata <= (hit && !pwrite) ? {22'h000000, ctrl_ff} : ERR_READ_DATA;
            end else begin
                pslverr <= 1'b0;
                prdata <= ERR_READ_DATA;
            end
        end
    end

    // ==========================================================
    // retention steering
    bank_retain_map u_map (
        .inBackup(inBackup),
        .ctrl(ctrl_ff),
        .drive(driveComb)
    );

    // outputs registered so the sequencer never sees decode glitches
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            retainDrive <= '0;
            regulatorRange <= RST_RANGE;
            supplyDetectBypass <= RST_DET_BYPASS;
        end else if (clkEn) begin
            retainDrive <= driveComb;
            regulatorRange <= ctrl_ff.voltRange;
            supplyDetectBypass <= ctrl_ff.detBypass;
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    // write data compared one cycle later, so take it from the edge it landed on
    write_readback_a: assert property (
        wrStrobe && clkEn && (&pstrb) |=> ctrl_ff == $past(pwdata[9:0]))
        else $error("register did not store written value");
    range_follow_a: assert property (
        clkEn |=> regulatorRange == $past(ctrl_ff.voltRange))
        else $error("regulator range does not follow field");
    bypass_follow_a: assert property (
        clkEn |=> supplyDetectBypass == $past(ctrl_ff.detBypass))
        else $error("detection bypass does not follow field");
    no_ret_out_a: assert property (
        clkEn && !inBackup |=> retainDrive == '0)
        else $error("retention active outside backup");
    dedicated_reg_a: assert property (
        clkEn && inBackup |=> retainDrive.dedicatedRegOn == $past(ctrl_ff.retRegEnable))
        else $error("retention regulator wrong in backup");
    bank3_keep_a: assert property (
        clkEn && inBackup |=> retainDrive.bankPowerOff[3] == !$past(ctrl_ff.bankKeep[3]))
        else $error("bank 3 retention wrong");
    bank2_keep_a: assert property (
        clkEn && inBackup |=> retainDrive.bankPowerOff[2] == !$past(ctrl_ff.bankKeep[2]))
        else $error("bank 2 retention wrong");
    bank1_keep_a: assert property (
        clkEn && inBackup && ctrl_ff.bankKeep[1] |=>
        (retainDrive.bankRetainMain[1] || retainDrive.bankRetainDedicated[1]))
        else $error("bank 1 not retained");
    bank0_keep_a: assert property (
        clkEn && inBackup && ctrl_ff.bankKeep[0] && !ctrl_ff.retRegEnable |=>
        retainDrive.bankRetainMain[0] && !retainDrive.dedicatedRegOn)
        else $error("bank 0 not kept from main supply");
    ready_timing_a: assert property (
        setupPhase && clkEn && state_ff == S_IDLE ##1 clkEn |-> pready)
        else $error("apb ready not one cycle after setup");

    // ==========================================================
    // bus protocol and clock enable
    ready_pulse_a: assert property (
        pready && clkEn |=> !pready)
        else $error("apb ready longer than one cycle");
    freeze_hold_a: assert property (
        !clkEn |=> $stable(ctrl_ff) && $stable(retainDrive) && $stable(pready)
        && $stable(prdata))
        else $error("state moved while clock enable low");
    err_decode_a: assert property (
        clkEn && setupPhase && state_ff == S_IDLE |=> pslverr == !$past(hit))
        else $error("apb error does not match decode");
    unmapped_write_a: assert property (
        clkEn && psel && penable && !hit |=> $stable(ctrl_ff))
        else $error("unmapped write changed the register");
    idle_read_a: assert property (
        !pready |-> prdata == ERR_READ_DATA && !pslverr)
        else $error("read data or error outside ready cycle");
    read_value_a: assert property (
        clkEn && setupPhase && state_ff == S_IDLE && hit && !pwrite |=>
        prdata == {22'h000000, $past(ctrl_ff)})
        else $error("read data is not the stored value");

    // ==========================================================
    // field writes and supply steering
    main_supply_a: assert property (
        clkEn && inBackup && !ctrl_ff.retRegEnable |=>
        retainDrive.bankRetainDedicated == 4'h0 && !retainDrive.dedicatedRegOn)
        else $error("dedicated regulator used while main supply selected");
    lane1_hold_a: assert property (
        wrStrobe && clkEn && !pstrb[1] |=>
        ctrl_ff.retRegEnable == $past(ctrl_ff.retRegEnable))
        else $error("regulator select written without its lane");
    range_write_a: assert property (
        wrStrobe && clkEn && pstrb[0] |=> ctrl_ff.voltRange == $past(pwdata[5:4]))
        else $error("range field did not take written value");
    bypass_write_a: assert property (
        wrStrobe && clkEn && pstrb[0] |=> ctrl_ff.detBypass == $past(pwdata[6]))
        else $error("bypass bit did not take written value");
    keep_write_a: assert property (
        wrStrobe && clkEn && pstrb[0] |=> ctrl_ff.bankKeep == $past(pwdata[3:0]))
        else $error("bank selections did not take written value");

    write_seen_c: cover property (wrStrobe && clkEn);
    backup_main_c: cover property (retainDrive.bankRetainMain != 4'h0);
    backup_ded_c: cover property (retainDrive.bankRetainDedicated != 4'h0);
    err_seen_c: cover property (pready && pslverr);
    freeze_c: cover property (!clkEn && inBackup);
endmodule : low_power_retention_control
`default_nettype wire

// ===== tb/tb_top.sv
/*
 * self-checking bench for the low-power retention control block: APB
 * master tasks, a register model and output checks at every result.
 * assumes the design package is compiled first; single 200 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin testsRun++; if ((g) !== (e)) begin failCount++; \
    $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module tb_top;
    import lp_retention_pkg::*;
    logic clk_sys = 1'b0, reset = 1'b1, clkEn = 1'b1, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, inBackup = 1'b0, pready, pslverr, er, supplyDetectBypass;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd, d;
    logic [3:0] pstrb = 4'h0, s;
    logic [1:0] regulatorRange;
    logic [9:0] m;
    retain_drive_t retainDrive;
    int failCount = 0, testsRun = 0;

    always #2.5 clk_sys = ~clk_sys;

    low_power_retention_control u_dut (.clk_sys(clk_sys), .reset(reset), .clkEn(clkEn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .inBackup(inBackup), .retainDrive(retainDrive), .regulatorRange(regulatorRange),
        .supplyDetectBypass(supplyDetectBypass));

    // ==========================================================
    // model of the retention steering
    function automatic logic [12:0] drv(input logic [9:0] c, input logic b);
        if (!b) return 13'h0;
        return {c[8], c[8] ? 4'h0 : c[3:0], c[8] ? c[3:0] : 4'h0, ~c[3:0]};
    endfunction : drv

    // ==========================================================
    // apb master
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] dd,
                       input logic [3:0] st);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= dd;
        pstrb <= st;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        // only the watchdog ends a wait that never sees ready
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        `CHK("wait", 1, n)
    endtask : apb

    task automatic check_all();
        apb(1'b0, 12'h000, 32'h0, 4'h0);
        `CHK("readback", {22'h0, m}, rd)
        `CHK("rd_err", 1'b0, er)
        `CHK("drive", drv(m, inBackup), retainDrive)
        `CHK("range", m[5:4], regulatorRange)
        `CHK("bypass", m[6], supplyDetectBypass)
    endtask : check_all

    task automatic finish_test();
        $display("checks %0d mismatches %0d", testsRun, failCount);
        if (failCount == 0 && testsRun > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : finish_test

    // ==========================================================
    // main sequence
    initial begin
        void'($urandom(32'hb873));
        m = 10'h120;
        repeat (10) @(posedge clk_sys);
        reset <= 1'b0;
        check_all();
        for (int i = 0; i < 40; i++) begin
            if (i == 30) begin
                // frozen clock enable: outputs keep what the last enabled edge made
                clkEn <= 1'b0;
                inBackup <= !inBackup;
                repeat (3) @(posedge clk_sys);
                `CHK("frozen", drv(m, !inBackup), retainDrive)
                clkEn <= 1'b1;
            end
            d = $urandom & 32'h17f;
            s = 4'($urandom);
            @(posedge clk_sys);
            inBackup <= 1'($urandom);
            if (i == 20) begin
                reset <= 1'b1;
                repeat (3) @(posedge clk_sys);
                `CHK("rst_range", 2'h2, regulatorRange)
                `CHK("rst_drive", 13'h0, retainDrive)
                `CHK("rst_bypass", 1'b0, supplyDetectBypass)
                reset <= 1'b0;
                m = 10'h120;
            end
            apb(1'b1, 12'h000, d, s);
            `CHK("wr_err", 1'b0, er)
            if (s[0]) m[7:0] = d[7:0];
            if (s[1]) m[9:8] = d[9:8];
            check_all();
            // unmapped place: refused, register left alone
            apb(i[0], 12'(($urandom & 12'hffc) | 12'h004), $urandom, 4'hf);
            `CHK("bad_err", 1'b1, er)
            `CHK("bad_rd", 32'h0, rd)
            check_all();
        end
        finish_test();
    end

    initial begin
        #20000;
        failCount++;
        finish_test();
    end
endmodule : tb_top
`undef CHK
`default_nettype wire
